// file: design/tvk_pkg.sv
package tvk_pkg;
	// Screen geometry
	localparam int COL_W = 7;
	localparam int ROW_W = 5;
	localparam int ADDR_W = 11;
	localparam int CODE_W = 7;
	localparam int DOT_W = 3;
	localparam int GROW_W = 3;
	localparam int GLYPH_W = 7;
	localparam int CELLS = 1920;
	localparam logic [COL_W-1:0] COL_LAST = 7'h4f;
	localparam logic [ROW_W-1:0] ROW_LAST = 5'h17;
	localparam logic [ADDR_W-1:0] CELL_LAST = 11'h77f;
	localparam logic [ADDR_W-1:0] ROW_STEP = 11'h050;
	localparam logic [DOT_W-1:0] DOT_LAST = 3'h6;
	localparam logic [GROW_W-1:0] GLYPH_LAST = 3'h6;

	// Line and frame timing, in characters and scan lines; transmitter tick in clock cycles
	localparam logic [COL_W-1:0] H_LAST = 7'h63;
	localparam logic [COL_W-1:0] HSYNC_START = 7'h54;
	localparam logic [COL_W-1:0] HSYNC_END = 7'h5c;
	localparam logic [2:0] GAP_LAST_60 = 3'h2;
	localparam logic [2:0] GAP_LAST_50 = 3'h3;
	localparam logic [ROW_W-1:0] VRET_LAST = 5'h13;
	localparam logic [ROW_W-1:0] VSYNC_START = 5'h04;
	localparam logic [ROW_W-1:0] VSYNC_END = 5'h08;
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_LAST = 4'hf;

	// Key matrix
	localparam int KEY_DRV = 8;
	localparam int KEY_SNS = 8;
	localparam int KEY_N = 64;
	localparam int KEY_IDX_W = 6;
	localparam logic [2:0] KEY_COL_LAST = 3'h7;
	localparam logic [2:0] KEY_SETTLE_LAST = 3'h5;
	localparam logic [KEY_IDX_W-1:0] KEY_LETTERS = 6'h1a;
	localparam logic [KEY_IDX_W-1:0] KEY_DIGITS_END = 6'h24;

	// Codes and glyph rows
	localparam logic [CODE_W-1:0] CODE_SPACE = 7'h20;
	localparam logic [CODE_W-1:0] CODE_UNDER = 7'h5f;
	localparam logic [CODE_W-1:0] CODE_DEL = 7'h7f;
	localparam logic [CODE_W-1:0] CODE_LOWER_A = 7'h61;
	localparam logic [CODE_W-1:0] CODE_ZERO = 7'h30;
	localparam logic [CODE_W-1:0] CODE_UPPER_A = 7'h41;
	localparam logic [7:0] TX_ESC = 8'h1b;
	localparam logic [GLYPH_W-1:0] GLYPH_FULL = 7'h7f;
	localparam logic [GLYPH_W-1:0] GLYPH_SIDES = 7'h41;
	localparam logic [GLYPH_W-1:0] GLYPH_NONE = 7'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [CODE_W-1:0] code;
	} tvk_cell_wr_t;

	typedef struct packed {
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} tvk_pos_t;

	typedef struct packed {
		logic video;
		logic blank;
		logic hsync;
		logic vsync;
	} tvk_crt_t;

	typedef enum logic [1:0] {
		V_GLYPH = 2'b00,
		V_GAP = 2'b01,
		V_RETRACE = 2'b10
	} tvk_vstate_t;

	typedef enum logic [2:0] {
		K_IDLE = 3'b000,
		K_DRIVE = 3'b001,
		K_JUDGE = 3'b010,
		K_SEND_ESC = 3'b011,
		K_SEND_CODE = 3'b100
	} tvk_kstate_t;
endpackage

// file: design/tvk_disp_ram.sv
`timescale 1ns/100ps
module tvk_disp_ram (
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [tvk_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [tvk_pkg::CODE_W-1:0] wr_data,
	input wire logic [tvk_pkg::ADDR_W-1:0] rd_addr,
	output logic [tvk_pkg::CODE_W-1:0] rd_data
);
	logic [tvk_pkg::CODE_W-1:0] mem [tvk_pkg::CELLS];

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read, one cycle latency
	always_ff @(posedge clk_sys)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule

// file: design/tvk_video_kbd.sv
`timescale 1ns/100ps
module tvk_video_kbd (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic mode_50hz,
	input wire logic cell_wr_valid,
	input wire tvk_pkg::tvk_cell_wr_t cell_wr,
	output logic cell_wr_ready,
	input wire logic clear_req,
	output logic clear_busy,
	input wire tvk_pkg::tvk_pos_t cursor_pos,
	output tvk_pkg::tvk_crt_t crt,
	output logic tx_tick,
	output logic [tvk_pkg::KEY_DRV-1:0] kbd_drive,
	input wire logic [tvk_pkg::KEY_SNS-1:0] kbd_sense,
	input wire logic tx_busy,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data
);
	logic m50_meta_q;
	logic m50_q;
	logic [tvk_pkg::KEY_SNS-1:0] sense_meta_q;
	logic [tvk_pkg::KEY_SNS-1:0] sense_q;
	logic [tvk_pkg::DOT_W-1:0] dot_q;
	logic [tvk_pkg::COL_W-1:0] hpos_q;
	logic [tvk_pkg::COL_W-1:0] x_addr_q;
	logic [tvk_pkg::ADDR_W-1:0] row_base_q;
	logic [tvk_pkg::ROW_W-1:0] trow_q;
	logic [tvk_pkg::ROW_W-1:0] gap_row_q;
	logic [tvk_pkg::GROW_W-1:0] grow_q;
	logic [2:0] gap_cnt_q;
	logic [tvk_pkg::ROW_W-1:0] vret_q;
	tvk_pkg::tvk_vstate_t vstate_q;
	logic [tvk_pkg::GLYPH_W-1:0] glyph_next_q;
	logic [tvk_pkg::GLYPH_W-1:0] shift_q;
	tvk_pkg::tvk_crt_t crt_q;
	logic [tvk_pkg::TICK_W-1:0] tick_cnt_q;
	logic tick_q;
	logic scan_start_q;
	logic clr_busy_q;
	logic [tvk_pkg::ADDR_W-1:0] clr_addr_q;
	tvk_pkg::tvk_kstate_t kstate_q;
	logic [2:0] kcol_q;
	logic [2:0] settle_q;
	logic [tvk_pkg::KEY_N-1:0] keys_q;
	logic [tvk_pkg::KEY_N-1:0] reported_q;
	logic [tvk_pkg::KEY_DRV-1:0] drive_q;
	logic [7:0] tx_data_q;

	logic char_end;
	logic line_end;
	logic fetch_pos;
	logic fetch_en;
	logic [tvk_pkg::COL_W-1:0] next_col;
	logic [2:0] gap_last;
	logic [tvk_pkg::ADDR_W-1:0] rd_addr;
	logic [tvk_pkg::CODE_W-1:0] rd_code;
	logic wr_en;
	logic [tvk_pkg::ADDR_W-1:0] wr_addr;
	logic [tvk_pkg::CODE_W-1:0] wr_data;
	logic key_found;
	logic [tvk_pkg::KEY_IDX_W-1:0] key_idx;
	logic [7:0] key_sel;

	// Character generator; a small stand-in font: blank, underline, else outlined box
	function automatic logic [tvk_pkg::GLYPH_W-1:0] glyph_row(
		input logic [tvk_pkg::CODE_W-1:0] code,
		input logic [tvk_pkg::GROW_W-1:0] row
	);
		logic edge_row;
		edge_row = (row == '0) || (row == tvk_pkg::GLYPH_LAST);
		if (code <= tvk_pkg::CODE_SPACE || code == tvk_pkg::CODE_DEL)
			glyph_row = tvk_pkg::GLYPH_NONE;
		else if (code == tvk_pkg::CODE_UNDER)
			glyph_row = (row == tvk_pkg::GLYPH_LAST) ? tvk_pkg::GLYPH_FULL : tvk_pkg::GLYPH_NONE;
		else
			glyph_row = edge_row ? tvk_pkg::GLYPH_FULL : tvk_pkg::GLYPH_SIDES;
	endfunction

	// Key index to code; bit 7 asks for an escape prefix
	function automatic logic [7:0] key_code(input logic [tvk_pkg::KEY_IDX_W-1:0] idx);
		logic [tvk_pkg::CODE_W-1:0] off;
		off = {1'b0, idx};
		if (idx < tvk_pkg::KEY_LETTERS)
			key_code = {1'b0, 7'(tvk_pkg::CODE_LOWER_A + off)};
		else if (idx < tvk_pkg::KEY_DIGITS_END)
			key_code = {1'b0, 7'(tvk_pkg::CODE_ZERO + off - {1'b0, tvk_pkg::KEY_LETTERS})};
		else
			key_code = {1'b1, 7'(tvk_pkg::CODE_UPPER_A + off - {1'b0, tvk_pkg::KEY_DIGITS_END})};
	endfunction

	// The mode pin and key sense inputs pass two flip-flops before use
	always_ff @(posedge clk_sys)
	begin
		m50_meta_q <= mode_50hz;
		m50_q <= m50_meta_q;
		sense_meta_q <= kbd_sense;
		sense_q <= sense_meta_q;
	end

	assign char_end = (dot_q == tvk_pkg::DOT_LAST);
	assign line_end = char_end && (hpos_q == tvk_pkg::COL_LAST);
	assign fetch_pos = (hpos_q < tvk_pkg::COL_LAST) || (hpos_q == tvk_pkg::H_LAST);
	assign fetch_en = (dot_q == '0) && fetch_pos;
	assign next_col = (hpos_q == tvk_pkg::H_LAST) ? '0 : 7'(hpos_q + 7'h01);
	assign gap_last = m50_q ? tvk_pkg::GAP_LAST_50 : tvk_pkg::GAP_LAST_60;
	assign rd_addr = 11'(row_base_q + {4'h0, x_addr_q});

	// Dot and character position counters
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			dot_q <= '0;
			hpos_q <= '0;
		end
		else if (char_end)
		begin
			dot_q <= '0;
			hpos_q <= (hpos_q == tvk_pkg::H_LAST) ? '0 : 7'(hpos_q + 7'h01);
		end
		else
		begin
			dot_q <= 3'(dot_q + 3'h1);
		end
	end

	// Column address: one step per fetch, zero at the end of the visible line
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			x_addr_q <= '0;
		else if (line_end)
			x_addr_q <= '0;
		else if (fetch_en)
			x_addr_q <= 7'(x_addr_q + 7'h01);
	end

	// Vertical sequencing steps at the end of the visible part of a line, so the
	// prefetch in horizontal retrace already sees the next line's row
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			vstate_q <= tvk_pkg::V_GLYPH;
			grow_q <= '0;
			gap_cnt_q <= '0;
			trow_q <= '0;
			gap_row_q <= '0;
			row_base_q <= '0;
			vret_q <= '0;
		end
		else if (line_end)
		begin
			unique case (vstate_q)
				tvk_pkg::V_GLYPH:
				begin
					if (grow_q == tvk_pkg::GLYPH_LAST)
					begin
						grow_q <= '0;
						gap_cnt_q <= '0;
						gap_row_q <= trow_q;
						vstate_q <= tvk_pkg::V_GAP;
						if (trow_q == tvk_pkg::ROW_LAST)
						begin
							trow_q <= '0;
							row_base_q <= '0;
						end
						else
						begin
							trow_q <= 5'(trow_q + 5'h01);
							row_base_q <= 11'(row_base_q + tvk_pkg::ROW_STEP);
						end
					end
					else
					begin
						grow_q <= 3'(grow_q + 3'h1);
					end
				end
				tvk_pkg::V_GAP:
				begin
					if (gap_cnt_q == gap_last)
					begin
						vret_q <= '0;
						vstate_q <= (gap_row_q == tvk_pkg::ROW_LAST) ? tvk_pkg::V_RETRACE : tvk_pkg::V_GLYPH;
					end
					else
					begin
						gap_cnt_q <= 3'(gap_cnt_q + 3'h1);
					end
				end
				tvk_pkg::V_RETRACE:
				begin
					if (vret_q == tvk_pkg::VRET_LAST)
						vstate_q <= tvk_pkg::V_GLYPH;
					else
						vret_q <= 5'(vret_q + 5'h01);
				end
				default:
				begin
					vstate_q <= tvk_pkg::V_GLYPH;
				end
			endcase
		end
	end

	// One pulse per frame on entry to vertical retrace
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			scan_start_q <= 1'b0;
		else
			scan_start_q <= line_end && vstate_q == tvk_pkg::V_GAP && gap_cnt_q == gap_last
				&& gap_row_q == tvk_pkg::ROW_LAST;
	end

	// Glyph lookup one cycle after the memory read
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			glyph_next_q <= '0;
		else if (dot_q == 3'h1)
			glyph_next_q <= glyph_row(rd_code, grow_q);
	end

	// Shifter: loads at each character boundary, dark outside glyph lines except the cursor bar on the first gap line
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			shift_q <= '0;
		else if (char_end)
		begin
			if (fetch_pos && vstate_q == tvk_pkg::V_GLYPH)
				shift_q <= glyph_next_q;
			else if (fetch_pos && vstate_q == tvk_pkg::V_GAP && gap_cnt_q == '0
				&& gap_row_q == cursor_pos.row && next_col == cursor_pos.col)
				shift_q <= tvk_pkg::GLYPH_FULL;
			else
				shift_q <= tvk_pkg::GLYPH_NONE;
		end
		else
			shift_q <= {shift_q[tvk_pkg::GLYPH_W-2:0], 1'b0};
	end

	// CRT outputs
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			crt_q <= '0;
		else
		begin
			crt_q.video <= shift_q[tvk_pkg::GLYPH_W-1];
			crt_q.blank <= (hpos_q > tvk_pkg::COL_LAST) || (vstate_q != tvk_pkg::V_GLYPH);
			crt_q.hsync <= (hpos_q >= tvk_pkg::HSYNC_START) && (hpos_q < tvk_pkg::HSYNC_END);
			crt_q.vsync <= (vstate_q == tvk_pkg::V_RETRACE) && (vret_q >= tvk_pkg::VSYNC_START)
				&& (vret_q < tvk_pkg::VSYNC_END);
		end
	end

	assign crt = crt_q;

	// Transmitter bit-rate strobe from its own counter, one pulse every 16 clock cycles
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= (tick_cnt_q == tvk_pkg::TICK_LAST) ? '0 : 4'(tick_cnt_q + 4'h1);
			tick_q <= (tick_cnt_q == tvk_pkg::TICK_LAST);
		end
	end

	assign tx_tick = tick_q;

	// Screen clear walks every cell; incoming stores wait meanwhile
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			clr_busy_q <= 1'b0;
			clr_addr_q <= '0;
		end
		else if (clr_busy_q)
		begin
			clr_addr_q <= 11'(clr_addr_q + 11'h001);
			clr_busy_q <= (clr_addr_q != tvk_pkg::CELL_LAST);
		end
		else if (clear_req)
		begin
			clr_busy_q <= 1'b1;
			clr_addr_q <= '0;
		end
	end

	assign clear_busy = clr_busy_q;
	assign cell_wr_ready = !clr_busy_q;
	assign wr_en = clr_busy_q || (cell_wr_valid && cell_wr.addr <= tvk_pkg::CELL_LAST);
	assign wr_addr = clr_busy_q ? clr_addr_q : cell_wr.addr;
	assign wr_data = clr_busy_q ? tvk_pkg::CODE_SPACE : cell_wr.code;

	tvk_disp_ram u_ram (
		.clk_sys(clk_sys),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_code)
	);

	// Lowest pressed key wins when several are new in one frame
	always_comb
	begin
		key_found = 1'b0;
		key_idx = '0;
		for (int i = tvk_pkg::KEY_N - 1; i >= 0; i--)
		begin
			if (keys_q[i])
			begin
				key_found = 1'b1;
				key_idx = 6'(i);
			end
		end
	end

	// Bit 7 only flags the escape prefix; it never goes out on the line
	assign key_sel = key_code(key_idx);

	// Keyboard scan sequencer
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			kstate_q <= tvk_pkg::K_IDLE;
			kcol_q <= '0;
			settle_q <= '0;
			keys_q <= '0;
			reported_q <= '0;
			tx_data_q <= '0;
		end
		else
		begin
			unique case (kstate_q)
				tvk_pkg::K_IDLE:
				begin
					if (scan_start_q && !tx_busy)
					begin
						kcol_q <= '0;
						settle_q <= '0;
						kstate_q <= tvk_pkg::K_DRIVE;
					end
				end
				tvk_pkg::K_DRIVE:
				begin
					if (settle_q == tvk_pkg::KEY_SETTLE_LAST)
					begin
						keys_q[{kcol_q, 3'h0} +: tvk_pkg::KEY_SNS] <= sense_q;
						settle_q <= '0;
						if (kcol_q == tvk_pkg::KEY_COL_LAST)
							kstate_q <= tvk_pkg::K_JUDGE;
						else
							kcol_q <= 3'(kcol_q + 3'h1);
					end
					else
						settle_q <= 3'(settle_q + 3'h1);
				end
				tvk_pkg::K_JUDGE:
				begin
					if (|(keys_q & reported_q))
						kstate_q <= tvk_pkg::K_IDLE;
					else if (key_found)
					begin
						reported_q <= tvk_pkg::KEY_N'(1) << key_idx;
						tx_data_q <= {1'b0, key_sel[tvk_pkg::CODE_W-1:0]};
						kstate_q <= key_sel[7] ? tvk_pkg::K_SEND_ESC : tvk_pkg::K_SEND_CODE;
					end
					else
					begin
						reported_q <= '0;
						kstate_q <= tvk_pkg::K_IDLE;
					end
				end
				tvk_pkg::K_SEND_ESC:
				begin
					if (tx_ready)
						kstate_q <= tvk_pkg::K_SEND_CODE;
				end
				tvk_pkg::K_SEND_CODE:
				begin
					if (tx_ready)
						kstate_q <= tvk_pkg::K_IDLE;
				end
				default:
				begin
					kstate_q <= tvk_pkg::K_IDLE;
				end
			endcase
		end
	end

	// Drive lags the column by a cycle; settle count covers it plus the synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			drive_q <= '0;
		else if (kstate_q == tvk_pkg::K_DRIVE)
			drive_q <= tvk_pkg::KEY_DRV'(1) << kcol_q;
		else
			drive_q <= '0;
	end

	assign kbd_drive = drive_q;
	assign tx_valid = (kstate_q == tvk_pkg::K_SEND_ESC) || (kstate_q == tvk_pkg::K_SEND_CODE);
	assign tx_data = (kstate_q == tvk_pkg::K_SEND_ESC) ? tvk_pkg::TX_ESC : tx_data_q;
endmodule

// file: verification/tvk_far_model.sv
`timescale 1ns/100ps
module tvk_far_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [tvk_pkg::KEY_DRV-1:0] kbd_drive,
	input wire logic [5:0] key_idx,
	input wire logic key_down,
	output logic [tvk_pkg::KEY_SNS-1:0] kbd_sense,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_busy
);
	logic [5:0] busy_q;
	// One closed key joins its drive column to its sense row
	always_comb
	begin
		kbd_sense = '0;
		kbd_sense[key_idx[2:0]] = key_down & kbd_drive[key_idx[5:3]];
	end
	// Slow on purpose: busy for 40 cycles after each byte it accepts
	assign tx_ready = busy_q == 6'h00;
	assign tx_busy = !tx_ready;
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			busy_q <= 6'h00;
		else if (tx_valid && tx_ready)
			busy_q <= 6'h28;
		else if (busy_q != 6'h00)
			busy_q <= busy_q - 6'h01;
	end
endmodule

// file: verification/tvk_video_kbd_props.sv
`timescale 1ns/100ps
module tvk_video_kbd_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clear_req,
	input wire logic clear_busy,
	input wire logic cell_wr_ready,
	input wire tvk_pkg::tvk_crt_t crt,
	input wire logic tx_tick,
	input wire logic [tvk_pkg::KEY_DRV-1:0] kbd_drive,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data
);
	logic [9:0] hs_q;
	logic [9:0] ln_q;
	logic [9:0] lo_q;
	logic [10:0] cb_q;
	logic seen_q;
	logic lo_ok_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Run lengths kept here; first partial runs after reset are skipped
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			hs_q <= 10'h000;
			ln_q <= 10'h000;
			lo_q <= 10'h000;
			cb_q <= 11'h000;
			seen_q <= 1'b0;
			lo_ok_q <= 1'b0;
		end
		else
		begin
			hs_q <= crt.hsync ? hs_q + 10'h001 : 10'h000;
			ln_q <= $rose(crt.hsync) ? 10'h001 : ln_q + 10'h001;
			lo_q <= crt.blank ? 10'h000 : lo_q + 10'h001;
			cb_q <= clear_busy ? cb_q + 11'h001 : 11'h000;
			seen_q <= seen_q | $rose(crt.hsync);
			lo_ok_q <= lo_ok_q | $fell(crt.blank);
		end
	end
	property p_hs_len;
		$fell(crt.hsync) |-> hs_q == 10'h038;
	endproperty
	a_hs_len: assert property (p_hs_len) else $error("hsync width wrong");
	property p_line;
		$rose(crt.hsync) && seen_q |-> ln_q == 10'h2bc;
	endproperty
	a_line: assert property (p_line) else $error("line period wrong");
	property p_vis;
		$rose(crt.blank) && lo_ok_q |-> lo_q == 10'h230;
	endproperty
	a_vis: assert property (p_vis) else $error("visible span wrong");
	property p_hs_dark;
		crt.hsync |-> crt.blank && !crt.video;
	endproperty
	a_hs_dark: assert property (p_hs_dark) else $error("video lit in retrace");
	property p_clr_start;
		clear_req && !clear_busy |=> clear_busy;
	endproperty
	a_clr_start: assert property (p_clr_start) else $error("clear not started");
	property p_clr_len;
		$fell(clear_busy) |-> cb_q == 11'h780;
	endproperty
	a_clr_len: assert property (p_clr_len) else $error("clear length wrong");
	property p_clr_ready;
		clear_busy |-> !cell_wr_ready;
	endproperty
	a_clr_ready: assert property (p_clr_ready) else $error("store open while clearing");
	property p_tick;
		tx_tick |-> ##16 tx_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick period wrong");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("key code dropped");
	property p_drive;
		$onehot0(kbd_drive);
	endproperty
	a_drive: assert property (p_drive) else $error("drive not one-hot");
	c_clear: cover property ($fell(clear_busy));
	c_line: cover property ($rose(crt.hsync) && seen_q);
	c_cursor: cover property (crt.video && crt.blank);
endmodule
bind tvk_video_kbd tvk_video_kbd_props u_props (.clk_sys(clk_sys), .reset(reset), .clear_req(clear_req),
	.clear_busy(clear_busy), .cell_wr_ready(cell_wr_ready), .crt(crt), .tx_tick(tx_tick),
	.kbd_drive(kbd_drive), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

// file: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic mode_50hz = 1'b0;
	logic cell_wr_valid = 1'b0;
	tvk_pkg::tvk_cell_wr_t cell_wr = '0;
	logic clear_req = 1'b0;
	tvk_pkg::tvk_pos_t cursor_pos = '{row: 5'h01, col: 7'h05};
	tvk_pkg::tvk_crt_t crt;
	logic cell_wr_ready, clear_busy, tx_tick, tx_busy, tx_valid, tx_ready;
	logic [7:0] kbd_drive, kbd_sense, tx_data;
	logic hs_prev = 1'b0;
	logic [559:0] dots [0:31];
	int vis [0:31];
	int lit [0:31];
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int ln = 0;
	int pos = 0;
	tvk_video_kbd dut (.clk_sys(clk_sys), .reset(reset), .mode_50hz(mode_50hz), .cell_wr_valid(cell_wr_valid),
		.cell_wr(cell_wr), .cell_wr_ready(cell_wr_ready), .clear_req(clear_req), .clear_busy(clear_busy),
		.cursor_pos(cursor_pos), .crt(crt), .tx_tick(tx_tick), .kbd_drive(kbd_drive), .kbd_sense(kbd_sense),
		.tx_busy(tx_busy), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
	tvk_far_model u_far (.clk_sys(clk_sys), .reset(reset), .kbd_drive(kbd_drive), .key_idx(6'h00),
		.key_down(1'b1), .kbd_sense(kbd_sense), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy));
	initial
		forever #2 clk_sys = ~clk_sys;
	// Visible line k ends before the (k+1)-th hsync rise, so ln indexes it
	// Sampled mid-cycle, clear of the edge that launches the outputs
	always @(negedge clk_sys)
	begin
		hs_prev <= crt.hsync;
		if (reset)
			ln <= 0;
		else if (crt.hsync && !hs_prev)
		begin
			ln <= ln + 1;
			pos <= 0;
		end
		else if (ln < 32)
		begin
			if (!crt.blank)
			begin
				dots[ln][559 - pos] <= crt.video;
				vis[ln] <= vis[ln] + 1;
				pos <= pos + 1;
			end
			lit[ln] <= lit[ln] + int'(crt.video);
		end
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 45000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_line(input int l, input logic [559:0] e);
		check_count++;
		if (dots[l] !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED line %0d expected %h seen %h", l, e, dots[l]);
		end
	endtask
	task automatic wrap_up;
		$display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask
	// Own stand-in font: box, underline, blank
	function automatic logic [6:0] gl(input logic [6:0] c, input int g);
		if (c == 7'h5f)
			return (g == 6) ? 7'h7f : 7'h00;
		if (c <= 7'h20 || c == 7'h7f)
			return 7'h00;
		return (g == 0 || g == 6) ? 7'h7f : 7'h41;
	endfunction
	function automatic logic [559:0] exp_line(input int g);
		logic [559:0] e;
		e = '0;
		e[559 -: 7] = gl(7'h41, g);
		e[552 -: 7] = gl(7'h5f, g);
		e[545 -: 7] = gl(7'h7f, g);
		e[6:0] = gl(7'h41, g);
		return e;
	endfunction
	task automatic do_reset;
		reset = 1'b1;
		repeat (3) step;
		for (int i = 0; i < 32; i++)
		begin
			vis[i] = 0;
			lit[i] = 0;
			dots[i] = '0;
		end
		chk("crt in reset", 32'h0, crt);
		chk("ready in reset", 32'h1, cell_wr_ready);
		chk("key side idle", 32'h0, {tx_valid, kbd_drive, tx_tick});
		reset = 1'b0;
	endtask
	task automatic wr(input logic [10:0] a, input logic [6:0] c);
		cell_wr_valid = 1'b1;
		cell_wr = '{addr: a, code: c};
		step;
	endtask
	task automatic t_clear;
		int n;
		int ticks;
		n = 0;
		ticks = 0;
		clear_req = 1'b1;
		step;
		clear_req = 1'b0;
		chk("busy", 32'h1, clear_busy);
		wr(11'h053, 7'h41);
		cell_wr_valid = 1'b0;
		chk("ready", 32'h0, cell_wr_ready);
		while (clear_busy === 1'b1 && n < 3000)
		begin
			if (n < 160)
				ticks = ticks + int'(tx_tick);
			n++;
			step;
		end
		chk("busy cycles", 32'h780, n + 1);
		chk("tick count", 32'd10, ticks);
		$display("Test clear done");
	endtask
	task automatic t_frame(input logic m);
		int g0;
		int l1;
		int n;
		mode_50hz = m;
		do_reset;
		t_clear;
		wr(11'h050, 7'h41);
		wr(11'h051, 7'h5f);
		wr(11'h052, 7'h7f);
		wr(11'h09f, 7'h41);
		cell_wr_valid = 1'b0;
		g0 = m ? 4 : 3;
		l1 = 7 + g0;
		n = 0;
		while (ln < l1 + 8 + g0 && n < 20000)
		begin
			n++;
			step;
		end
		for (int k = 0; k < 7; k++)
		begin
			chk_line(l1 + k, exp_line(k));
			chk("visible dots", 32'd560, vis[l1 + k]);
		end
		for (int k = 0; k < g0; k++)
		begin
			chk("gap visible", 32'h0, vis[l1 + 7 + k]);
			chk("gap lit", (k == 0) ? 32'h7 : 32'h0, lit[l1 + 7 + k]);
		end
		chk("next row visible", 32'd560, vis[l1 + 7 + g0]);
		chk_line(l1 + 7 + g0, '0);
		$display("Test frame mode %0d done", m);
	endtask
	initial
	begin
		t_frame(1'b0);
		t_frame(1'b1);
		wrap_up();
	end
endmodule
